// ### hw/vio_func_map.sv
// Maps active sources onto the input function codes they are assigned to
`timescale 1ns/1ps
module vio_func_map
    import vio_pkg::*;
#(
    parameter int N_SRC = 8,
    parameter int N_FUNC = VIO_N_FUNC
) (
    input wire logic [N_SRC*VIO_FUNC_W-1:0] sel_flat,  // Selector of each source
    input wire logic [N_SRC-1:0] src_active,           // Active state of each source
    output logic [N_FUNC-1:0] func_active              // One bit per function code
);
    // ****************************************************
    // Parameter check
    // ****************************************************
    if (N_SRC < 1 || N_FUNC < 2 || N_FUNC > 64) begin : g_bad
        $error("vio_func_map: unsupported size");
    end

    // Function 0 means no function, so bit 0 never rises
    always_comb begin
        func_active = '0;
        for (int s = 0; s < N_SRC; s++) begin
            for (int f = 1; f < N_FUNC; f++) begin
                if (src_active[s] && sel_flat[s*VIO_FUNC_W +: VIO_FUNC_W] == VIO_FUNC_W'(f)) begin
                    func_active[f] = 1'b1;
                end
            end
        end
    end
endmodule : vio_func_map

// ### hw/vio_hyst.sv
// Threshold comparator with hysteresis for one analog channel
`timescale 1ns/1ps
module vio_hyst
    import vio_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] level_mv,   // Channel voltage in millivolts
    output logic level_high              // Digital level after hysteresis
);
    // ****************************************************
    // Hysteresis state
    // ****************************************************
    logic level_r;                       // Held level
    logic level_nxt;

    // Between the two thresholds the old level is kept, so noise cannot chatter
    always_comb begin
        level_nxt = level_r;
        if (level_mv >= VIO_HIGH_MV) begin
            level_nxt = 1'b1;
        end else if (level_mv <= VIO_LOW_MV) begin
            level_nxt = 1'b0;
        end
    end

    // Register once per clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign level_high = level_r;
endmodule : vio_hyst

// ### hw/vio_map.sv
// Virtual input/output mapping with analog-as-digital inputs and APB registers
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps

module vio_map
    import vio_pkg::*;
#(
    parameter int N_VIN = VIO_N_VIN,
    parameter int N_AN = VIO_N_AN
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] phys_input,
    input wire logic [39:0] drive_status,
    input wire logic [15:0] first_analog_channel_mv,
    input wire logic [15:0] second_analog_channel_mv,
    input wire logic [15:0] third_analog_channel_mv,
    output logic [4:0] virtual_input_state,
    output logic [4:0] virtual_output_state,
    output logic [2:0] analog_channel_state,
    output logic [59:0] func_active,
    output logic forward_run,
    output logic user_fault_code
);
    // ****************************************************
    // Parameter check
    // ****************************************************
    // Digit registers and status fields are laid out for exactly these counts
    if (N_VIN != VIO_N_VIN || N_AN != VIO_N_AN) begin : g_bad
        $error("vio_map: only five virtual inputs and three analog channels supported");
    end

    localparam int N_SRC = N_VIN + N_AN;  // Sources feeding the function map

    // ****************************************************
    // Helper functions
    // ****************************************************
    // Byte address of word i of a register group
    function automatic logic [11:0] addr_of(input logic [11:0] base, input int i);
        addr_of = base + 12'(i * 4);
    endfunction : addr_of

    // Range check of a written selector
    function automatic logic sel_ok(input logic [31:0] wd, input logic [5:0] max);
        sel_ok = (wd[31:6] == 26'h0) && (wd[5:0] <= max);
    endfunction : sel_ok

    // ****************************************************
    // Pin synchroniser for physical inputs
    // ****************************************************
    logic [4:0] phys_meta_r;              // First stage, read only by second
    logic [4:0] phys_sync_r;              // Second stage, safe to use
    logic [4:0] phys_meta_nxt;
    logic [4:0] phys_sync_nxt;

    // Next values of the two stages
    always_comb begin
        phys_meta_nxt = phys_input;
        phys_sync_nxt = phys_meta_r;
    end

    // Two flops, the pins are asynchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phys_meta_r <= 5'h00;
            phys_sync_r <= 5'h00;
        end else begin
            phys_meta_r <= phys_meta_nxt;
            phys_sync_r <= phys_sync_nxt;
        end
    end

    // ****************************************************
    // APB handshake
    // ****************************************************
    logic pready_r;                        // No wait state, ready in the first access cycle
    logic pslverr_r;                       // Error on unmapped access
    logic [31:0] prdata_r;                 // Read data captured at setup
    logic pready_nxt;
    logic pslverr_nxt;
    logic [31:0] prdata_nxt;
    logic access_done;                     // Transfer completes this edge
    logic wr_en;                           // Write takes effect this edge
    logic hit;                             // Address is a register
    logic [31:0] rd_word;                  // Read mux result

    assign access_done = psel && penable && pready_r;
    assign wr_en = access_done && pwrite && !pslverr_r;

    // ****************************************************
    // Configuration registers
    // ****************************************************
    logic [5:0] vin_func_r [VIO_N_VIN];    // Virtual input functions
    logic [5:0] an_func_r [VIO_N_AN];      // Analog channel functions
    logic [5:0] vout_func_r [VIO_N_VIN];   // Virtual output functions
    logic [4:0] state_source_mode_r;       // One: software, zero: paired output
    logic [4:0] software_state_setting_r;  // Software states
    logic [2:0] analog_input_polarity_r;   // One: low level active
    logic [4:0] output_logic_select_r;     // One: invert
    logic [5:0] vin_func_nxt [VIO_N_VIN];
    logic [5:0] an_func_nxt [VIO_N_AN];
    logic [5:0] vout_func_nxt [VIO_N_VIN];
    logic [4:0] state_source_mode_nxt;
    logic [4:0] software_state_setting_nxt;
    logic [2:0] analog_input_polarity_nxt;
    logic [4:0] output_logic_select_nxt;

    // Selectors outside their range are ignored, the old value stays
    always_comb begin
        vin_func_nxt = vin_func_r;
        an_func_nxt = an_func_r;
        vout_func_nxt = vout_func_r;
        state_source_mode_nxt = state_source_mode_r;
        software_state_setting_nxt = software_state_setting_r;
        analog_input_polarity_nxt = analog_input_polarity_r;
        output_logic_select_nxt = output_logic_select_r;
        if (wr_en) begin
            for (int i = 0; i < VIO_N_VIN; i++) begin
                if (paddr == addr_of(VIO_OFF_VIN_FUNC0, i) && sel_ok(pwdata, VIO_IN_FUNC_MAX)) begin
                    vin_func_nxt[i] = pwdata[5:0];
                end
                if (paddr == addr_of(VIO_OFF_VOUT_FUNC0, i) && sel_ok(pwdata, VIO_OUT_FUNC_MAX)) begin
                    vout_func_nxt[i] = pwdata[5:0];
                end
            end
            for (int i = 0; i < VIO_N_AN; i++) begin
                if (paddr == addr_of(VIO_OFF_AN_FUNC0, i) && sel_ok(pwdata, VIO_IN_FUNC_MAX)) begin
                    an_func_nxt[i] = pwdata[5:0];
                end
            end
            // Bit k is the digit of input, analog channel or output k+1, lowest first
            if (paddr == VIO_OFF_SRC_MODE) begin
                state_source_mode_nxt = pwdata[4:0];
            end
            if (paddr == VIO_OFF_SW_STATE) begin
                software_state_setting_nxt = pwdata[4:0];
            end
            if (paddr == VIO_OFF_AN_POL) begin
                analog_input_polarity_nxt = pwdata[2:0];
            end
            if (paddr == VIO_OFF_VOUT_LOGIC) begin
                output_logic_select_nxt = pwdata[4:0];
            end
        end
    end

    // Register the configuration, all zero after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < VIO_N_VIN; i++) begin
                vin_func_r[i] <= VIO_RST_FUNC;
                vout_func_r[i] <= VIO_RST_FUNC;
            end
            for (int i = 0; i < VIO_N_AN; i++) begin
                an_func_r[i] <= VIO_RST_FUNC;
            end
            state_source_mode_r <= VIO_RST_DIG5;
            software_state_setting_r <= VIO_RST_DIG5;
            analog_input_polarity_r <= VIO_RST_DIG3;
            output_logic_select_r <= VIO_RST_DIG5;
        end else begin
            vin_func_r <= vin_func_nxt;
            vout_func_r <= vout_func_nxt;
            an_func_r <= an_func_nxt;
            state_source_mode_r <= state_source_mode_nxt;
            software_state_setting_r <= software_state_setting_nxt;
            analog_input_polarity_r <= analog_input_polarity_nxt;
            output_logic_select_r <= output_logic_select_nxt;
        end
    end

    // ****************************************************
    // Analog channels as digital inputs
    // ****************************************************
    logic [15:0] an_mv [VIO_N_AN];         // Channel voltages as an array
    logic [2:0] an_level;                  // Levels after hysteresis

    assign an_mv[0] = first_analog_channel_mv;
    assign an_mv[1] = second_analog_channel_mv;
    assign an_mv[2] = third_analog_channel_mv;

    for (genvar g = 0; g < VIO_N_AN; g++) begin : g_hyst
        vio_hyst u_hyst (
            .pclk(pclk),
            .presetn(presetn),
            .level_mv(an_mv[g]),
            .level_high(an_level[g])
        );
    end

    // ****************************************************
    // Live states
    // ****************************************************
    logic [4:0] vout_r;                    // Virtual output states
    logic [4:0] vin_r;                     // Virtual input states
    logic [2:0] an_r;                      // Analog channel active states
    logic [4:0] vout_nxt;
    logic [4:0] vin_nxt;
    logic [2:0] an_nxt;
    logic [5:0] vout_sel;                  // Scratch selector

    // Each state is one stage behind its cause, so config edits act next cycle
    always_comb begin
        vout_sel = 6'h00;
        for (int i = 0; i < VIO_N_VIN; i++) begin
            vout_sel = vout_func_r[i];
            if (vout_sel == VIO_OUT_MIRROR) begin
                vout_nxt[i] = phys_sync_r[i];
            end else begin
                vout_nxt[i] = drive_status[vout_sel - 6'h01];
            end
            vout_nxt[i] = vout_nxt[i] ^ output_logic_select_r[i];
            // Fixed one-to-one pairing, input i reads only output i
            vin_nxt[i] = state_source_mode_r[i] ? software_state_setting_r[i] : vout_r[i];
        end
        an_nxt = an_level ^ analog_input_polarity_r;
    end

    // Register the states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vout_r <= 5'h00;
            vin_r <= 5'h00;
            an_r <= 3'h0;
        end else begin
            vout_r <= vout_nxt;
            vin_r <= vin_nxt;
            an_r <= an_nxt;
        end
    end

    // ****************************************************
    // Function assignment
    // ****************************************************
    logic [N_SRC*VIO_FUNC_W-1:0] src_sel;  // Selectors of all sources
    logic [N_SRC-1:0] src_act;             // Active flags of all sources
    logic [59:0] func_now;                 // Combined function vector

    always_comb begin
        for (int i = 0; i < VIO_N_VIN; i++) begin
            src_sel[i*VIO_FUNC_W +: VIO_FUNC_W] = vin_func_r[i];
        end
        for (int i = 0; i < VIO_N_AN; i++) begin
            src_sel[(VIO_N_VIN+i)*VIO_FUNC_W +: VIO_FUNC_W] = an_func_r[i];
        end
        src_act = {an_r, vin_r};
    end

    vio_func_map #(
        .N_SRC(N_SRC),
        .N_FUNC(VIO_N_FUNC)
    ) u_map (
        .sel_flat(src_sel),
        .src_active(src_act),
        .func_active(func_now)
    );

    // ****************************************************
    // Function outputs and user fault
    // ****************************************************
    logic [59:0] func_r;                   // Registered function vector
    logic fwd_r;                           // Forward run command
    logic fault_r;                         // Sticky user fault
    logic [59:0] func_nxt;
    logic fwd_nxt;
    logic fault_nxt;
    logic fault_clr;                       // Software clears the fault

    // A new fault in the clear cycle wins, so no fault is lost
    always_comb begin
        func_nxt = func_now;
        fwd_nxt = func_now[VIO_FN_FORWARD];
        fault_clr = wr_en && paddr == VIO_OFF_FAULT && pwdata[VIO_FAULT_BIT];
        fault_nxt = (fault_r && !fault_clr) || func_now[VIO_FN_USER_FAULT];
    end

    // Register, nothing active after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_r <= 60'h000000000000000;
            fwd_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            func_r <= func_nxt;
            fwd_r <= fwd_nxt;
            fault_r <= fault_nxt;
        end
    end

    // ****************************************************
    // Read mux and bus answer
    // ****************************************************
    // Decode once at setup; the answer is ready in the first access cycle
    always_comb begin
        rd_word = 32'h00000000;
        hit = 1'b0;
        for (int i = 0; i < VIO_N_VIN; i++) begin
            if (paddr == addr_of(VIO_OFF_VIN_FUNC0, i)) begin
                hit = 1'b1;
                rd_word = {26'h0, vin_func_r[i]};
            end
            if (paddr == addr_of(VIO_OFF_VOUT_FUNC0, i)) begin
                hit = 1'b1;
                rd_word = {26'h0, vout_func_r[i]};
            end
        end
        for (int i = 0; i < VIO_N_AN; i++) begin
            if (paddr == addr_of(VIO_OFF_AN_FUNC0, i)) begin
                hit = 1'b1;
                rd_word = {26'h0, an_func_r[i]};
            end
        end
        unique case (paddr)
            VIO_OFF_SRC_MODE: begin
                hit = 1'b1;
                rd_word = {27'h0, state_source_mode_r};
            end
            VIO_OFF_SW_STATE: begin
                hit = 1'b1;
                rd_word = {27'h0, software_state_setting_r};
            end
            VIO_OFF_AN_POL: begin
                hit = 1'b1;
                rd_word = {29'h0, analog_input_polarity_r};
            end
            VIO_OFF_VOUT_LOGIC: begin
                hit = 1'b1;
                rd_word = {27'h0, output_logic_select_r};
            end
            VIO_OFF_STATUS: begin
                hit = 1'b1;
                rd_word = {19'h0, an_r, vout_r, vin_r};
            end
            VIO_OFF_FAULT: begin
                hit = 1'b1;
                rd_word = {31'h0, fault_r};
            end
            default: begin
                // Function words handled above
            end
        endcase
        pready_nxt = psel && !penable && !pready_r;
        pslverr_nxt = (psel && !penable) ? !hit : (pslverr_r && !access_done);
        prdata_nxt = (psel && !penable) ? (hit ? rd_word : 32'h00000000) : prdata_r;
        if (access_done) begin
            pready_nxt = 1'b0;
        end
    end

    // Register the bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ****************************************************
    // Outputs, all straight from flops
    // ****************************************************
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign virtual_input_state = vin_r;
    assign virtual_output_state = vout_r;
    assign analog_channel_state = an_r;
    assign func_active = func_r;
    assign forward_run = fwd_r;
    assign user_fault_code = fault_r;
endmodule : vio_map

// ### shared/vio_pkg.sv
// Constants shared by the virtual input/output mapping block
package vio_pkg;
    // ****************************************************
    // Sizes and function codes
    // ****************************************************
    localparam int VIO_N_VIN = 5;                  // Virtual inputs, also virtual outputs
    localparam int VIO_N_AN = 3;                   // Analog channels usable as digital inputs
    localparam int VIO_FUNC_W = 6;                 // Width of a function selector
    localparam int VIO_N_FUNC = 60;                // Input function codes 0..59
    localparam int VIO_N_STATUS = 40;              // Drive status functions 1..40
    localparam logic [5:0] VIO_IN_FUNC_MAX = 6'h3B;   // Highest input function, 59
    localparam logic [5:0] VIO_OUT_FUNC_MAX = 6'h28;  // Highest output function, 40
    localparam logic [5:0] VIO_FN_FORWARD = 6'h01;    // Forward run command
    localparam logic [5:0] VIO_FN_USER_FAULT = 6'h2C; // User-defined fault 1, 44
    localparam logic [5:0] VIO_OUT_MIRROR = 6'h00;    // Output mirrors physical input

    // ****************************************************
    // Analog thresholds, in millivolts
    // ****************************************************
    localparam logic [15:0] VIO_HIGH_MV = 16'h1B58;   // 7000 mV reads high
    localparam logic [15:0] VIO_LOW_MV = 16'h0BB8;    // 3000 mV reads low

    // ****************************************************
    // Register byte offsets
    // ****************************************************
    localparam logic [11:0] VIO_OFF_VIN_FUNC0 = 12'h000;  // Five words, input function selectors
    localparam logic [11:0] VIO_OFF_SRC_MODE = 12'h014;   // State source mode digits
    localparam logic [11:0] VIO_OFF_SW_STATE = 12'h018;   // Software state setting digits
    localparam logic [11:0] VIO_OFF_AN_FUNC0 = 12'h01C;   // Three words, analog function selectors
    localparam logic [11:0] VIO_OFF_AN_POL = 12'h028;     // Analog input polarity digits
    localparam logic [11:0] VIO_OFF_VOUT_FUNC0 = 12'h02C; // Five words, output function selectors
    localparam logic [11:0] VIO_OFF_VOUT_LOGIC = 12'h040; // Output logic select digits
    localparam logic [11:0] VIO_OFF_STATUS = 12'h044;     // Live states, read only
    localparam logic [11:0] VIO_OFF_FAULT = 12'h048;      // Sticky user fault, write one to clear

    // ****************************************************
    // Field positions and reset values
    // ****************************************************
    localparam int VIO_ST_VIN_LSB = 0;             // Status: virtual input states
    localparam int VIO_ST_VOUT_LSB = 5;            // Status: virtual output states
    localparam int VIO_ST_AN_LSB = 10;             // Status: analog channel states
    localparam int VIO_FAULT_BIT = 0;              // Fault register bit
    localparam logic [5:0] VIO_RST_FUNC = 6'h00;
    localparam logic [4:0] VIO_RST_DIG5 = 5'h00;
    localparam logic [2:0] VIO_RST_DIG3 = 3'h00;
endpackage : vio_pkg

// ### sim/vio_map_checker.sv
// Port checker of the virtual input/output mapping block
`timescale 1ns/1ps
// ********************
// Checker
// ********************
module vio_map_checker
    import vio_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [4:0] virtual_input_state,
    input wire logic [2:0] analog_channel_state,
    input wire logic [59:0] func_active,
    input wire logic forward_run,
    input wire logic user_fault_code
);
    logic clr_w; // Completing write of one to the fault bit
    assign clr_w = psel && penable && pready && pwrite && paddr == VIO_OFF_FAULT && pwdata[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_rise; !user_fault_code ##1 user_fault_code; endsequence
    AST_READY: assert property (s_setup |=> pready) else $error("no ready after setup");
    AST_ONE: assert property (pready |=> !pready) else $error("ready held too long");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
    AST_FWD: assert property (forward_run == func_active[1]) else $error("forward run off");
    AST_FN0: assert property (!func_active[0]) else $error("function zero active");
    // Idle sources can never raise any function
    AST_IDLE: assert property (virtual_input_state == 5'h00 && analog_channel_state == 3'h0 |=> func_active == 60'h0) else $error("idle function");
    // Fault flop and function vector load from the same term, so they rise together
    AST_SET: assert property (func_active[44] |-> user_fault_code) else $error("fault not raised");
    AST_HOLD: assert property (user_fault_code && !clr_w |=> user_fault_code) else $error("fault lost");
    // The set term of the clear cycle shows in the function vector one edge later
    AST_CLEAR: assert property (clr_w ##1 !func_active[44] |-> !user_fault_code) else $error("fault kept");
    AST_CAUSE: assert property (s_rise |-> func_active[44]) else $error("fault no cause");
endmodule : vio_map_checker
bind vio_map vio_map_checker u_vio_map_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .virtual_input_state, .analog_channel_state, .func_active, .forward_run,
    .user_fault_code);

// ### sim/vio_map_tb_top.sv
// Self-checking bench of the virtual input/output mapping block
`timescale 1ns/1ps
module vio_map_tb_top;
    import vio_pkg::*;
    // ********************
    // Signals
    // ********************
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, forward_run, user_fault_code;
    logic [4:0] phys_input = 5'h00, virtual_input_state, virtual_output_state;
    logic [39:0] drive_status = 40'h0;
    logic [15:0] mv0 = 16'h0000, mv1 = 16'h0000, mv2 = 16'h0000; // Analog channels
    logic [2:0] analog_channel_state;
    logic [59:0] func_active;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    vio_map u_vio_map (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .phys_input, .drive_status, .first_analog_channel_mv(mv0), .second_analog_channel_mv(mv1),
        .third_analog_channel_mv(mv2), .virtual_input_state, .virtual_output_state, .analog_channel_state,
        .func_active, .forward_run, .user_fault_code);
    initial begin
        forever #10 pclk = ~pclk;
    end
    // Hang guard, far above the roughly 130 cycles needed
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            close_out();
        end
    end
    // ********************
    // Shared tasks
    // ********************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; waits for ready, no fixed latency assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        logic [11:0] offs [6] = '{VIO_OFF_VIN_FUNC0, VIO_OFF_SRC_MODE, VIO_OFF_SW_STATE, VIO_OFF_AN_FUNC0,
            VIO_OFF_AN_POL, VIO_OFF_VOUT_LOGIC};
        foreach (offs[i]) begin
            apb(1'h0, offs[i], 32'h0);
            chk(rd, 64'h0);
        end
    endtask : t_reset
    task automatic t_soft();
        apb(1'h1, VIO_OFF_VIN_FUNC0, 32'h1);
        apb(1'h1, 12'h008, 32'h2);
        apb(1'h1, VIO_OFF_SRC_MODE, 32'h1F);
        apb(1'h1, VIO_OFF_SW_STATE, 32'h05);
        repeat (4) @(posedge pclk);
        chk(virtual_input_state, 64'h05);
        chk(forward_run, 64'h1);
        chk(func_active[2], 64'h1);
        apb(1'h1, VIO_OFF_VIN_FUNC0, 32'h3C); // Out of range, ignored
        apb(1'h0, VIO_OFF_VIN_FUNC0, 32'h0);
        chk(rd, 64'h1);
        apb(1'h1, 12'h04C, 32'h1); // Unmapped
        chk({err, rd}, 64'h100000000);
    endtask : t_soft
    task automatic t_pair();
        apb(1'h1, VIO_OFF_SRC_MODE, 32'h0);
        phys_input <= 5'h12;
        repeat (6) @(posedge pclk);
        chk(virtual_output_state, 64'h12);
        chk(virtual_input_state, 64'h12);
        apb(1'h1, VIO_OFF_VOUT_LOGIC, 32'h1);
        apb(1'h1, 12'h030, 32'h28);
        repeat (3) @(posedge pclk);
        chk(virtual_output_state, 64'h11);
        drive_status <= 40'h8000000000;
        repeat (3) @(posedge pclk);
        chk(virtual_output_state, 64'h13);
        apb(1'h0, VIO_OFF_STATUS, 32'h0);
        chk(rd, 64'h273);
    endtask : t_pair
    task automatic t_fault();
        apb(1'h1, VIO_OFF_VIN_FUNC0, 32'h2C);
        repeat (4) @(posedge pclk);
        chk(user_fault_code, 64'h1);
        apb(1'h0, VIO_OFF_FAULT, 32'h0);
        chk(rd, 64'h1);
        apb(1'h1, VIO_OFF_VOUT_LOGIC, 32'h0);
        repeat (4) @(posedge pclk);
        chk(user_fault_code, 64'h1);
        apb(1'h1, VIO_OFF_FAULT, 32'h1);
        @(posedge pclk);
        chk(user_fault_code, 64'h0);
    endtask : t_fault
    task automatic t_analog();
        apb(1'h1, VIO_OFF_AN_FUNC0, 32'h5);
        mv0 <= VIO_HIGH_MV;
        repeat (4) @(posedge pclk);
        chk({analog_channel_state[0], func_active[5]}, 64'h3);
        mv0 <= 16'h1388; // Between thresholds, holds
        repeat (4) @(posedge pclk);
        chk(analog_channel_state, 64'h1);
        mv0 <= VIO_LOW_MV;
        repeat (4) @(posedge pclk);
        chk(analog_channel_state, 64'h0);
        apb(1'h1, VIO_OFF_AN_POL, 32'h1);
        repeat (3) @(posedge pclk);
        chk(analog_channel_state, 64'h1);
    endtask : t_analog
    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_soft();
        t_pair();
        t_fault();
        t_analog();
        close_out();
    end
endmodule : vio_map_tb_top
